// File: inc/apsc_pkg.sv
// Purpose: Shared constants and types for the asynchronous pseudo-static RAM host controller.
// Assumes: A 100 MHz clock; every pin interval is rounded up to whole clock periods.
// Notes: Fast grade is the default; the top module selects the slow grade by parameter.
//
// What this block does
// - Random reads spaced at least 65 ns (fast) or 75 ns (slow); data valid then.
// - Page address changes no faster than 18 ns or 25 ns; new word valid then.
// - Output enable follows chip select within 10,000 ns and never stays high longer.
// - Those two maximum limits apply only while chip select is held low.
// - Output enable low 45 ns minimum before select rises; high pulses 2 ns minimum.
// - Chip select and both byte enables stay high at least 10 ns between accesses.
// - Address is stable by the falling edge of output enable, zero setup.
// - Address hold counts from the moment both byte enables are high.
// - During reads write enable and standby control stay high.
// - Write sees address and byte enables 55 or 60 ns; spacing 65 or 75 ns.
// - Write enable low at least 50 or 55 ns, high 10 ns between writes.
// - Write data valid 30 or 35 ns before write end, held zero or more.
// - Held select: write enable falls 0-10,000 ns after output enable rises; reverse 10-10,000 ns.
// - Standby control held low 50 us after power, raised only with chip select high.
// - First chip select comes at least 200 us after standby control rises.
// - Standby mode two entry: chip select high first, then standby control low.
// - Exit with partial retention waits 30 ns before chip select falls.
// - Exit with no retention waits 200 us before chip select falls.
// - Address moves in writes only with select or write enable high; standby, output enable high.

package apsc_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int PAGE_W = 4;
  localparam int LEN_W = 4;
  localparam int TMR_W = 15;
  localparam int SYNC_STAGES = 2;

  localparam int CLK_NS = 10;

  // Rounding up keeps every minimum satisfied at the cost of a little bandwidth.
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int T_RC_FAST_NS = 65;
  localparam int T_RC_SLOW_NS = 75;
  localparam int T_PRC_FAST_NS = 18;
  localparam int T_PRC_SLOW_NS = 25;
  localparam int T_OLCH_NS = 45;
  localparam int T_CP_NS = 10;
  localparam int T_HZ_NS = 25;
  localparam int T_CW_FAST_NS = 55;
  localparam int T_CW_SLOW_NS = 60;
  localparam int T_WP_FAST_NS = 50;
  localparam int T_WP_SLOW_NS = 55;
  localparam int T_DW_FAST_NS = 30;
  localparam int T_DW_SLOW_NS = 35;
  localparam int T_WC_FAST_NS = 65;
  localparam int T_WC_SLOW_NS = 75;
  localparam int T_WHP_NS = 10;
  localparam int T_MHCL1_NS = 30;
  localparam int T_VHMH_US = 50;
  localparam int T_MHCL_US = 200;

  localparam int RC_FAST_CYC = ns_to_cyc(T_RC_FAST_NS);
  localparam int RC_SLOW_CYC = ns_to_cyc(T_RC_SLOW_NS);
  localparam int PRC_FAST_CYC = ns_to_cyc(T_PRC_FAST_NS);
  localparam int PRC_SLOW_CYC = ns_to_cyc(T_PRC_SLOW_NS);
  localparam int OLCH_CYC = ns_to_cyc(T_OLCH_NS);
  localparam int CP_CYC = ns_to_cyc(T_CP_NS);
  localparam int HZ_CYC = ns_to_cyc(T_HZ_NS);
  localparam int CW_FAST_CYC = ns_to_cyc(T_CW_FAST_NS);
  localparam int CW_SLOW_CYC = ns_to_cyc(T_CW_SLOW_NS);
  localparam int WP_FAST_CYC = ns_to_cyc(T_WP_FAST_NS);
  localparam int WP_SLOW_CYC = ns_to_cyc(T_WP_SLOW_NS);
  localparam int DW_FAST_CYC = ns_to_cyc(T_DW_FAST_NS);
  localparam int DW_SLOW_CYC = ns_to_cyc(T_DW_SLOW_NS);
  localparam int WC_FAST_CYC = ns_to_cyc(T_WC_FAST_NS);
  localparam int WC_SLOW_CYC = ns_to_cyc(T_WC_SLOW_NS);
  localparam int WHP_CYC = ns_to_cyc(T_WHP_NS);
  localparam int MHCL1_CYC = ns_to_cyc(T_MHCL1_NS);
  localparam int VHMH_CYC = ns_to_cyc(T_VHMH_US * 1000);
  localparam int MHCL_CYC = ns_to_cyc(T_MHCL_US * 1000);

  typedef enum logic [8:0] {
    ST_POWER = 9'b0_0000_0001,
    ST_INIT = 9'b0_0000_0010,
    ST_IDLE = 9'b0_0000_0100,
    ST_READ = 9'b0_0000_1000,
    ST_PAGE = 9'b0_0001_0000,
    ST_WRITE = 9'b0_0010_0000,
    ST_RECOV = 9'b0_0100_0000,
    ST_SLEEP = 9'b0_1000_0000,
    ST_WAKE = 9'b1_0000_0000
  } apsc_state_t;

endpackage

// File: hw/apsc_timer.sv
// Purpose: Down-counter that measures every pin interval of the controller.
// Assumes: The owner loads the interval minus one; expired then rises after that many cycles.
// Notes: The reset value is a constant so that the power-up hold starts without a load.
`timescale 1ns/1ns

module apsc_timer #(
  parameter logic [apsc_pkg::TMR_W-1:0] RESET_LOAD = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [apsc_pkg::TMR_W-1:0] load_value,
  output logic expired
);

  logic [apsc_pkg::TMR_W-1:0] count_q;
  logic [apsc_pkg::TMR_W-1:0] count_d;
  wire running = (count_q != '0);

  assign count_d = load ? load_value : (running ? count_q - 1'b1 : count_q);
  assign expired = ~running;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= RESET_LOAD;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// File: hw/apsc_ctrl.sv
// Purpose: Host controller that runs reads, page reads, writes and standby mode two on the RAM pins.
// Assumes: One 100 MHz clock; read data pass two flip-flops before use.
// Notes: Every pin leaves a flip-flop, so pin edges line up with clock edges.
`timescale 1ns/1ns

module apsc_ctrl #(
  parameter bit SLOW_GRADE = 1'b0,
  parameter int INIT_LOW_CYC = apsc_pkg::VHMH_CYC,
  parameter int INIT_WAIT_CYC = apsc_pkg::MHCL_CYC,
  parameter int WAKE_FULL_CYC = apsc_pkg::MHCL_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [apsc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [1:0] req_byte_en,
  input wire logic [apsc_pkg::DATA_W-1:0] req_wdata,
  input wire logic [apsc_pkg::LEN_W-1:0] req_len,
  output logic rsp_valid,
  output logic rsp_last,
  output logic [apsc_pkg::DATA_W-1:0] rsp_data,
  input wire logic sleep_req,
  input wire logic sleep_keep,
  output logic init_done,
  output logic standby,
  output logic [apsc_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_cs_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic lower_byte_enable_n,
  output logic upper_byte_enable_n,
  output logic mem_mode,
  input wire logic [apsc_pkg::DATA_W-1:0] mem_dq_i,
  output logic [apsc_pkg::DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe
);

  localparam int TW = apsc_pkg::TMR_W;
  localparam int AW = apsc_pkg::ADDR_W;
  localparam int DW = apsc_pkg::DATA_W;
  localparam int PW = apsc_pkg::PAGE_W;

  // Read data are sampled two cycles late, so the window counts the synchroniser too.
  localparam int RC_CYC = SLOW_GRADE ? apsc_pkg::RC_SLOW_CYC : apsc_pkg::RC_FAST_CYC;
  localparam int RD_CYC = apsc_pkg::cyc_max(RC_CYC, apsc_pkg::OLCH_CYC) + apsc_pkg::SYNC_STAGES;
  localparam int PRC_CYC = SLOW_GRADE ? apsc_pkg::PRC_SLOW_CYC : apsc_pkg::PRC_FAST_CYC;
  localparam int PG_CYC = PRC_CYC + apsc_pkg::SYNC_STAGES;
  localparam int CW_CYC = SLOW_GRADE ? apsc_pkg::CW_SLOW_CYC : apsc_pkg::CW_FAST_CYC;
  localparam int WP_CYC = SLOW_GRADE ? apsc_pkg::WP_SLOW_CYC : apsc_pkg::WP_FAST_CYC;
  localparam int DWR_CYC = SLOW_GRADE ? apsc_pkg::DW_SLOW_CYC : apsc_pkg::DW_FAST_CYC;
  localparam int WC_CYC = SLOW_GRADE ? apsc_pkg::WC_SLOW_CYC : apsc_pkg::WC_FAST_CYC;
  localparam int WR_CYC = apsc_pkg::cyc_max(apsc_pkg::cyc_max(CW_CYC, WP_CYC), DWR_CYC);
  localparam int WREC_CYC = apsc_pkg::cyc_max(apsc_pkg::cyc_max(WC_CYC - WR_CYC, apsc_pkg::CP_CYC),
                                              apsc_pkg::WHP_CYC);
  // Recovery after a read also covers the device's release time before we may drive data.
  localparam int RREC_CYC = apsc_pkg::cyc_max(apsc_pkg::HZ_CYC, apsc_pkg::CP_CYC);

  localparam logic [TW-1:0] LD_INIT_LOW = TW'(INIT_LOW_CYC - 1);
  localparam logic [TW-1:0] LD_INIT_WAIT = TW'(INIT_WAIT_CYC - 1);
  localparam logic [TW-1:0] LD_WAKE_FULL = TW'(WAKE_FULL_CYC - 1);
  localparam logic [TW-1:0] LD_WAKE_KEEP = TW'(apsc_pkg::MHCL1_CYC - 1);
  localparam logic [TW-1:0] LD_RD = TW'(RD_CYC - 1);
  localparam logic [TW-1:0] LD_PG = TW'(PG_CYC - 1);
  localparam logic [TW-1:0] LD_WR = TW'(WR_CYC - 1);
  localparam logic [TW-1:0] LD_WREC = TW'(WREC_CYC - 1);
  localparam logic [TW-1:0] LD_RREC = TW'(RREC_CYC - 1);

  apsc_pkg::apsc_state_t state_q;
  apsc_pkg::apsc_state_t state_d;

  logic tmr_load;
  logic [TW-1:0] tmr_value;
  logic tmr_expired;

  logic [DW-1:0] dq_s1_q;
  logic [DW-1:0] dq_s2_q;

  logic [AW-1:0] addr_q;
  logic [AW-1:0] addr_d;
  logic cs_n_q;
  logic cs_n_d;
  logic oe_n_q;
  logic oe_n_d;
  logic we_n_q;
  logic we_n_d;
  logic lb_n_q;
  logic lb_n_d;
  logic ub_n_q;
  logic ub_n_d;
  logic mode_q;
  logic mode_d;
  logic [DW-1:0] dq_o_q;
  logic [DW-1:0] dq_o_d;
  logic dq_oe_q;
  logic dq_oe_d;

  logic [apsc_pkg::LEN_W-1:0] left_q;
  logic [apsc_pkg::LEN_W-1:0] left_d;
  logic retain_q;
  logic retain_d;
  logic ready_q;
  logic rsp_valid_q;
  logic rsp_valid_d;
  logic rsp_last_q;
  logic rsp_last_d;
  logic [DW-1:0] rsp_data_q;
  logic [DW-1:0] rsp_data_d;
  logic init_done_q;
  logic init_done_d;
  logic standby_q;

  wire st_idle = (state_q == apsc_pkg::ST_IDLE);
  wire take = st_idle & req_valid & ready_q;
  wire more_words = (left_q != '0);
  wire [AW-1:0] page_next_addr = {addr_q[AW-1:PW], addr_q[PW-1:0] + 1'b1};
  wire [apsc_pkg::LEN_W-1:0] left_dec = left_q - 1'b1;
  wire [TW-1:0] wake_load = retain_q ? LD_WAKE_KEEP : LD_WAKE_FULL;

  apsc_timer #(
    .RESET_LOAD(LD_INIT_LOW)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .load(tmr_load),
    .load_value(tmr_value),
    .expired(tmr_expired)
  );

  always_comb begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_value = '0;
    addr_d = addr_q;
    cs_n_d = cs_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    lb_n_d = lb_n_q;
    ub_n_d = ub_n_q;
    mode_d = mode_q;
    dq_o_d = dq_o_q;
    dq_oe_d = dq_oe_q;
    left_d = left_q;
    retain_d = retain_q;
    rsp_valid_d = 1'b0;
    rsp_last_d = 1'b0;
    rsp_data_d = rsp_data_q;
    init_done_d = init_done_q;
    unique case (state_q)
      apsc_pkg::ST_POWER: begin
        // Chip select has been high since reset, so the standby line may rise now.
        if (tmr_expired) begin
          mode_d = 1'b1;
          state_d = apsc_pkg::ST_INIT;
          tmr_load = 1'b1;
          tmr_value = LD_INIT_WAIT;
        end
      end
      apsc_pkg::ST_INIT: begin
        if (tmr_expired) begin
          init_done_d = 1'b1;
          state_d = apsc_pkg::ST_IDLE;
        end
      end
      apsc_pkg::ST_IDLE: begin
        // Address and strobes move together on the same edge that drives chip select low.
        if (take) begin
          addr_d = req_addr;
          cs_n_d = 1'b0;
          lb_n_d = ~req_byte_en[0];
          ub_n_d = ~req_byte_en[1];
          tmr_load = 1'b1;
          if (req_write) begin
            we_n_d = 1'b0;
            dq_o_d = req_wdata;
            dq_oe_d = 1'b1;
            state_d = apsc_pkg::ST_WRITE;
            tmr_value = LD_WR;
          end else begin
            oe_n_d = 1'b0;
            left_d = req_len;
            state_d = apsc_pkg::ST_READ;
            tmr_value = LD_RD;
          end
        end else if (sleep_req) begin
          mode_d = 1'b0;
          retain_d = sleep_keep;
          state_d = apsc_pkg::ST_SLEEP;
        end
      end
      apsc_pkg::ST_READ, apsc_pkg::ST_PAGE: begin
        if (tmr_expired) begin
          rsp_valid_d = 1'b1;
          rsp_data_d = dq_s2_q;
          tmr_load = 1'b1;
          if (more_words) begin
            left_d = left_dec;
            addr_d = page_next_addr;
            state_d = apsc_pkg::ST_PAGE;
            tmr_value = LD_PG;
          end else begin
            rsp_last_d = 1'b1;
            cs_n_d = 1'b1;
            oe_n_d = 1'b1;
            lb_n_d = 1'b1;
            ub_n_d = 1'b1;
            state_d = apsc_pkg::ST_RECOV;
            tmr_value = LD_RREC;
          end
        end
      end
      apsc_pkg::ST_WRITE: begin
        // Data may be released on the same edge as write end because the hold is zero.
        if (tmr_expired) begin
          we_n_d = 1'b1;
          cs_n_d = 1'b1;
          lb_n_d = 1'b1;
          ub_n_d = 1'b1;
          dq_oe_d = 1'b0;
          state_d = apsc_pkg::ST_RECOV;
          tmr_load = 1'b1;
          tmr_value = LD_WREC;
        end
      end
      apsc_pkg::ST_RECOV: begin
        if (tmr_expired) begin
          state_d = apsc_pkg::ST_IDLE;
        end
      end
      apsc_pkg::ST_SLEEP: begin
        if (!sleep_req) begin
          mode_d = 1'b1;
          state_d = apsc_pkg::ST_WAKE;
          tmr_load = 1'b1;
          tmr_value = wake_load;
        end
      end
      apsc_pkg::ST_WAKE: begin
        if (tmr_expired) begin
          state_d = apsc_pkg::ST_IDLE;
        end
      end
      default: begin
        // A corrupted state code restarts the whole power-up sequence.
        state_d = apsc_pkg::ST_POWER;
        cs_n_d = 1'b1;
        oe_n_d = 1'b1;
        we_n_d = 1'b1;
        lb_n_d = 1'b1;
        ub_n_d = 1'b1;
        mode_d = 1'b0;
        dq_oe_d = 1'b0;
        init_done_d = 1'b0;
        tmr_load = 1'b1;
        tmr_value = LD_INIT_LOW;
      end
    endcase
  end

  // Read data come from another timing domain and are only read after the second stage.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= mem_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= apsc_pkg::ST_POWER;
      left_q <= '0;
      retain_q <= 1'b0;
      ready_q <= 1'b0;
      init_done_q <= 1'b0;
      standby_q <= 1'b0;
    end else begin
      state_q <= state_d;
      left_q <= left_d;
      retain_q <= retain_d;
      ready_q <= (state_d == apsc_pkg::ST_IDLE);
      init_done_q <= init_done_d;
      standby_q <= (state_d == apsc_pkg::ST_SLEEP);
    end
  end

  // Strobes reset inactive and standby control low, which starts the power-up hold.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      lb_n_q <= 1'b1;
      ub_n_q <= 1'b1;
      mode_q <= 1'b0;
    end else begin
      cs_n_q <= cs_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      lb_n_q <= lb_n_d;
      ub_n_q <= ub_n_d;
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_q <= '0;
      dq_o_q <= '0;
      dq_oe_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      dq_o_q <= dq_o_d;
      dq_oe_q <= dq_oe_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_last_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_valid_q <= rsp_valid_d;
      rsp_last_q <= rsp_last_d;
      rsp_data_q <= rsp_data_d;
    end
  end

  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_last = rsp_last_q;
  assign rsp_data = rsp_data_q;
  assign init_done = init_done_q;
  assign standby = standby_q;
  assign mem_addr = addr_q;
  assign mem_cs_n = cs_n_q;
  assign mem_oe_n = oe_n_q;
  assign mem_we_n = we_n_q;
  assign lower_byte_enable_n = lb_n_q;
  assign upper_byte_enable_n = ub_n_q;
  assign mem_mode = mode_q;
  assign mem_dq_o = dq_o_q;
  assign mem_dq_oe = dq_oe_q;

endmodule

// File: tb/apsc_ctrl_sva.sv
// Purpose: Pin timing checks for the pseudo-static RAM host controller.
// Assumes: Fast grade and one clock; every strobe leaves a flip-flop.
// Notes: Counters stand in for the long power-up holds, which no repetition could reach.
`timescale 1ns/1ns

module apsc_ctrl_sva #(
  parameter int INIT_LOW_CYC = 8,
  parameter int INIT_WAIT_CYC = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic init_done,
  input wire logic [apsc_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_cs_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic lower_byte_enable_n,
  input wire logic upper_byte_enable_n,
  input wire logic mem_mode,
  input wire logic [apsc_pkg::DATA_W-1:0] mem_dq_o,
  input wire logic mem_dq_oe
);
  int up_q;
  int hi_q;
  wire lanes_off = lower_byte_enable_n & upper_byte_enable_n;
  wire [apsc_pkg::ADDR_W-apsc_pkg::PAGE_W-1:0] addr_hi = mem_addr[apsc_pkg::ADDR_W-1:apsc_pkg::PAGE_W];
  wire [31:0] up_d = (up_q < 100000) ? up_q + 1 : up_q;
  wire [31:0] hi_d = !mem_mode ? 0 : ((hi_q < 100000) ? hi_q + 1 : hi_q);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      up_q <= 0;
      hi_q <= 0;
    end else begin
      up_q <= up_d;
      hi_q <= hi_d;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_read_open;
    !mem_oe_n && !mem_cs_n;
  endsequence
  sequence s_we_low;
    !mem_we_n;
  endsequence
  AST_READ_QUIET: assert property ((!mem_cs_n && !mem_oe_n) |-> mem_we_n && mem_mode)
    else $error("write enable or standby control low during a read");
  AST_ONE_STROBE: assert property ($fell(mem_cs_n) |-> mem_oe_n != mem_we_n)
    else $error("select fell without exactly one of output or write enable");
  AST_OE_HOLD: assert property ($fell(mem_oe_n) |-> s_read_open [*5])
    else $error("output enable low too briefly before select rose");
  AST_CS_PULSE: assert property ($rose(mem_cs_n) |=> mem_cs_n)
    else $error("select high pulse too short");
  AST_LANE_PULSE: assert property ($rose(lanes_off) |=> lanes_off)
    else $error("byte enables high pulse too short");
  AST_WE_WIDTH: assert property ($fell(mem_we_n) |-> s_we_low [*5] ##1 (!$fell(mem_we_n)) [*2])
    else $error("write pulse too short or writes too close");
  AST_DATA_SETUP: assert property ($rose(mem_we_n) |-> $past(mem_dq_oe, 3) &&
      $past(mem_dq_o, 3) == $past(mem_dq_o))
    else $error("write data not settled before end of write");
  AST_WR_ADDR: assert property ((!mem_we_n && !$past(mem_we_n)) |-> $stable(mem_addr) && mem_oe_n && mem_mode)
    else $error("address or strobes moved inside a write");
  AST_RD_ADDR: assert property ((!mem_cs_n && !$past(mem_cs_n)) |-> $stable(addr_hi))
    else $error("address moved beyond the page while selected");
  AST_MODE_CS: assert property ($changed(mem_mode) |-> mem_cs_n && $past(mem_cs_n))
    else $error("standby control moved while selected");
  AST_WAKE: assert property ($rose(mem_mode) |-> mem_cs_n [*3])
    else $error("select fell too soon after standby control rose");
  AST_INIT_LOW: assert property (($rose(mem_mode) && !init_done) |-> up_q >= INIT_LOW_CYC)
    else $error("standby control rose too early after power-up");
  AST_INIT_WAIT: assert property ($rose(init_done) |-> hi_q >= INIT_WAIT_CYC)
    else $error("power-up wait too short");
  COV_PAGE: cover property (s_read_open ##1 $changed(mem_addr));
endmodule

bind apsc_ctrl apsc_ctrl_sva #(.INIT_LOW_CYC(INIT_LOW_CYC), .INIT_WAIT_CYC(INIT_WAIT_CYC)) i_apsc_ctrl_sva (
  .clock(clock), .rst(rst), .init_done(init_done), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
  .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .lower_byte_enable_n(lower_byte_enable_n),
  .upper_byte_enable_n(upper_byte_enable_n), .mem_mode(mem_mode), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));

// File: tb/apsc_ram_model.sv
// Purpose: Behavioural model of the pseudo-static RAM on the controller's pins.
// Assumes: Fast grade; only the low 256 words are stored.
// Notes: Undriven or changing data shows the inverse of the last value, never a kind guess.
`timescale 1ns/1ns

module apsc_ram_model (
  input wire logic clock,
  input wire logic [apsc_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_cs_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic lower_byte_enable_n,
  input wire logic upper_byte_enable_n,
  input wire logic mem_mode,
  input wire logic [apsc_pkg::DATA_W-1:0] mem_dq_o,
  input wire logic mem_dq_oe,
  output logic [apsc_pkg::DATA_W-1:0] mem_dq_i
);
  logic [apsc_pkg::DATA_W-1:0] mem [256];
  int tok = 0;
  logic rd_was = 1'b0;
  time t_open = 0;
  logic [apsc_pkg::ADDR_W-1:0] addr_was = '0;
  wire wr_on = !mem_cs_n && !mem_we_n && mem_mode && mem_dq_oe;
  wire rd_on = !mem_cs_n && !mem_oe_n && mem_we_n && mem_mode;
  initial mem_dq_i = 16'h0000;
  always @(posedge clock) begin
    if (wr_on && !lower_byte_enable_n) mem[mem_addr[7:0]][7:0] <= mem_dq_o[7:0];
    if (wr_on && !upper_byte_enable_n) mem[mem_addr[7:0]][15:8] <= mem_dq_o[15:8];
  end
  // A newer change cancels every answer still pending, so a stale word never lands late.
  always @(mem_addr or rd_on) begin
    tok = tok + 1;
    if (rd_on && !rd_was) t_open = $time;
    fork
      automatic int my = tok;
      automatic bit rd = rd_on;
      automatic bit pg = rd_on && ($time > t_open) && (mem_addr[21:4] == addr_was[21:4]);
      automatic logic [7:0] idx = mem_addr[7:0];
      begin
        #5;
        if (my == tok) mem_dq_i = ~mem_dq_i;
        if (rd) begin
          #(pg ? 13 : 60);
          if (my == tok) mem_dq_i = mem[idx];
        end
      end
    join_none
    rd_was = rd_on;
    addr_was = mem_addr;
  end
endmodule

// File: tb/apsc_ctrl_tb.sv
// Purpose: Self-checking bench for the pseudo-static RAM host controller.
// Assumes: Fast grade with shortened power-up and wake counts.
// Notes: Requests are raised on a rising edge and held until req_ready is seen.
`timescale 1ns/1ns

module apsc_ctrl_tb;
  localparam int LOW_C = 8;
  localparam int WAIT_C = 20;
  localparam int WAKE_C = 20;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [21:0] req_addr = '0;
  logic [1:0] req_byte_en = '0;
  logic [15:0] req_wdata = '0;
  logic [3:0] req_len = '0;
  logic sleep_req = 1'b0;
  logic sleep_keep = 1'b0;
  logic req_ready, rsp_valid, rsp_last, init_done, standby, mem_cs_n, mem_oe_n, mem_we_n;
  logic lower_byte_enable_n, upper_byte_enable_n, mem_mode, mem_dq_oe;
  logic [15:0] rsp_data, mem_dq_i, mem_dq_o;
  logic [21:0] mem_addr;
  logic [15:0] got [$];
  int failures = 0;
  int n_tests = 0;

  apsc_ctrl #(.INIT_LOW_CYC(LOW_C), .INIT_WAIT_CYC(WAIT_C), .WAKE_FULL_CYC(WAKE_C)) i_apsc_ctrl (
    .clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_byte_en(req_byte_en), .req_wdata(req_wdata), .req_len(req_len),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_data(rsp_data), .sleep_req(sleep_req),
    .sleep_keep(sleep_keep), .init_done(init_done), .standby(standby), .mem_addr(mem_addr),
    .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .lower_byte_enable_n(lower_byte_enable_n),
    .upper_byte_enable_n(upper_byte_enable_n), .mem_mode(mem_mode), .mem_dq_i(mem_dq_i),
    .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
  apsc_ram_model i_apsc_ram_model (
    .clock(clock), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
    .lower_byte_enable_n(lower_byte_enable_n), .upper_byte_enable_n(upper_byte_enable_n),
    .mem_mode(mem_mode), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i));

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic timeout();
    failures++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask

  task automatic reset_init();
    int n;
    n = 0;
    @(posedge clock);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    check({mem_cs_n, mem_oe_n, mem_we_n, mem_mode, mem_dq_oe, req_ready}, 6'b111000);
    rst <= 1'b0;
    while (init_done !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > 1000) timeout();
      check(mem_cs_n, 1'b1);
    end
    check(mem_mode, 1'b1);
    check(n >= LOW_C + WAIT_C, 1'b1);
  endtask

  task automatic send(input logic w, input logic [21:0] a, input logic [1:0] be, input logic [15:0] d,
                      input logic [3:0] len);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_byte_en <= be;
    req_wdata <= d;
    req_len <= len;
    do begin
      @(negedge clock);
      n++;
      if (n > 30000) timeout();
    end while (req_ready !== 1'b1);
    @(posedge clock);
    req_valid <= 1'b0;
  endtask

  task automatic read(input logic [21:0] a, input logic [3:0] len);
    int n;
    n = 0;
    got.delete();
    send(1'b0, a, 2'b11, 16'h0000, len);
    while (got.size() <= len) begin
      @(negedge clock);
      n++;
      if (n > 200) timeout();
      if (rsp_valid === 1'b1) begin
        got.push_back(rsp_data);
        check(rsp_last, got.size() == len + 1);
      end
    end
  endtask

  // Back-to-back writes, then single lanes, so a lost lane or a merged word shows up.
  task automatic t_write_read();
    send(1'b1, 22'h00_0123, 2'b11, 16'hA5C3, 4'h0);
    send(1'b1, 22'h00_0124, 2'b11, 16'h5A3C, 4'h0);
    read(22'h00_0123, 4'h0);
    check(got[0], 16'hA5C3);
    send(1'b1, 22'h00_0123, 2'b01, 16'h1177, 4'h0);
    send(1'b1, 22'h00_0124, 2'b10, 16'h88FF, 4'h0);
    read(22'h00_0123, 4'h0);
    check(got[0], 16'hA577);
    read(22'h00_0124, 4'h0);
    check(got[0], 16'h883C);
  endtask

  // The burst starts two words from the page end to force the wrap.
  task automatic t_page();
    for (int i = 0; i < 4; i++) send(1'b1, {18'h0_0003, 4'(14 + i)}, 2'b11, 16'hC000 + 16'(i), 4'h0);
    read({18'h0_0003, 4'hE}, 4'h3);
    check(got.size(), 4);
    for (int i = 0; i < 4; i++) check(got[i], 16'hC000 + 16'(i));
  endtask

  task automatic t_sleep(input logic keep);
    int n;
    n = 0;
    @(posedge clock);
    sleep_keep <= keep;
    sleep_req <= 1'b1;
    do begin
      @(negedge clock);
      n++;
      if (n > 100) timeout();
    end while (standby !== 1'b1);
    check({mem_mode, mem_cs_n, req_ready}, 3'b010);
    repeat (10) @(posedge clock);
    sleep_req <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n > 30000) timeout();
    end while (req_ready !== 1'b1);
    check(n >= (keep ? apsc_pkg::MHCL1_CYC : WAKE_C) + 1, 1'b1);
    check(standby, 1'b0);
    if (keep) begin
      read(22'h00_0123, 4'h0);
      check(got[0], 16'hA577);
    end
  endtask

  // A reset in mid-run must repeat the whole power-up sequence before the first access.
  task automatic t_rerun();
    reset_init();
    read(22'h00_0124, 4'h0);
    check(got[0], 16'h883C);
  endtask

  initial begin
    reset_init();
    t_write_read();
    t_page();
    t_sleep(1'b1);
    t_sleep(1'b0);
    t_rerun();
    end_sim();
  end
endmodule
